// ---- rtl/pbf_pkg.sv ----
package pbf_pkg;

  // protection functions in fixed order
  localparam int unsigned PBF_NFUNC = 7;
  localparam int unsigned PBF_F_THERM_A = 0;
  localparam int unsigned PBF_F_THERM_T = 1;
  localparam int unsigned PBF_F_OVERCUR = 2;
  localparam int unsigned PBF_F_SHORT = 3;
  localparam int unsigned PBF_F_EARTH_LO = 4;
  localparam int unsigned PBF_F_EARTH_HI = 5;
  localparam int unsigned PBF_F_CBFP = 6;
  localparam int unsigned PBF_NSTAGE = 6;
  localparam int unsigned PBF_NRELAY = 4;

  // per-function blocked flags at reset: only the short-circuit stage
  localparam logic [6:0] PBF_BLOCK_RST = 7'h08;

  // timing
  localparam int unsigned PBF_CLK_HZ = 250_000_000;
  localparam int unsigned PBF_TICK_US = 1000;
  localparam int unsigned PBF_TICK_CYC = PBF_CLK_HZ / 1_000_000 * PBF_TICK_US;
  localparam int unsigned PBF_CBF_MIN_MS = 100;
  localparam int unsigned PBF_CBF_MAX_MS = 2000;
  localparam logic [11:0] PBF_CBF_RST_MS = 12'h0064;
  localparam logic [15:0] PBF_BT_RST_MS = 16'h0064;

  // current threshold in percent of nominal
  localparam int unsigned PBF_THRESH_PCT = 1;

  // blocking style
  typedef enum logic [1:0] {
    PBF_STYLE_PICKUP = 2'b01,
    PBF_STYLE_TRIP = 2'b10
  } pbf_style_e;

  // per-stage measurement from protection logic
  typedef struct packed {
    logic [5:0] pickup;
    logic [5:0] delay_done;
  } pbf_stage_s;

  // relay assignment: alarm and trip masks, one bit per function per relay
  typedef struct packed {
    logic [3:0][6:0] alarm;
    logic [3:0][6:0] trip;
  } pbf_assign_s;

  localparam pbf_assign_s PBF_ASSIGN_RST = '0;

endpackage

// ---- rtl/pbf_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module pbf_timer #(
  parameter int unsigned TICK_CYC = 250_000,
  parameter int unsigned W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [W-1:0] limit_ms,
  // status
  output logic expired
);
  // elaboration check on parameters
  generate
    if (TICK_CYC < 1 || W < 1 || W > 31) begin : g_bad_param
      $error("pbf_timer: parameter out of range");
    end
  endgenerate

  logic [31:0] pre_q, pre_d;
  logic [W-1:0] cnt_q, cnt_d;
  logic exp_q, exp_d;

  // restart from zero when run drops
  always_comb begin
    pre_d = '0;
    cnt_d = '0;
    exp_d = 1'b0;
    if (run) begin
      exp_d = exp_q || (cnt_q >= limit_ms);
      pre_d = pre_q + 32'd1;
      cnt_d = cnt_q;
      if (pre_q == 32'(TICK_CYC - 1)) begin
        pre_d = '0;
        if (!exp_d) cnt_d = cnt_q + W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;
endmodule
`default_nettype wire

// ---- rtl/pbf_core.sv ----
// Summary of operation
// RULE1 - breaker supervision idle normally, armed only after a trip is issued
// RULE2 - armed: check all phase currents fall below one percent nominal in time
// RULE3 - breaker fail time setting spans 0.1 s to 2.0 s
// RULE4 - current still at threshold on expiry: declare failure, drive assigned relays
// RULE5 - supervision disarms once all currents are below threshold in time
// RULE6 - blocking input blocks only functions individually marked blockable
// RULE7 - pickup style: blocked stage cannot pick up
// RULE8 - trip style: stage picks up and times, trips after blocking input drops
// RULE9 - trip style, input held: trip when stage delay and block/trip time expire
// RULE10 - block/trip timer runs only with blocking input and trip style
// RULE11 - after block/trip expiry trip only picked-up stages with expired delay
// RULE12 - one blocked flag per function, one global blocking style
// RULE13 - default: only short-circuit stage blocked
// RULE14 - five relays, fifth is self-supervision alarm energized normally
// RULE15 - relays one to four off by default, assignable as alarm or trip
// RULE16 - assignments writable from front panel and serial port
// RULE17 - alarm relays follow pickup, trip relays follow expired delay
// RULE18 - timers count fixed ticks and restart on each new trigger
`timescale 1ns/1ps
`default_nettype none
module pbf_core
  import pbf_pkg::*;
#(
  parameter int unsigned PHASE_W = 16,
  parameter int unsigned TICK_CYC = PBF_TICK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // measured phase currents and nominal current
  input wire logic [2:0][PHASE_W-1:0] phase_current,
  input wire logic [PHASE_W-1:0] nominal_current,
  // protection stages
  input wire pbf_pkg::pbf_stage_s stage,
  // blocking input terminals level
  input wire logic blocking_input_terminals,
  // self-supervision health
  input wire logic supervision_ok,
  // configuration from front panel
  input wire logic panel_cfg_we,
  input wire logic [6:0] panel_function_blocked,
  input wire pbf_pkg::pbf_style_e panel_style,
  input wire logic [11:0] panel_breaker_fail_time,
  input wire logic [15:0] panel_block_trip_time,
  input wire logic panel_assign_we,
  input wire pbf_pkg::pbf_assign_s panel_assign,
  // configuration from serial port
  input wire logic serial_cfg_we,
  input wire logic [6:0] serial_function_blocked,
  input wire pbf_pkg::pbf_style_e serial_style,
  input wire logic [11:0] serial_breaker_fail_time,
  input wire logic [15:0] serial_block_trip_time,
  input wire logic serial_assign_we,
  input wire pbf_pkg::pbf_assign_s serial_assign,
  // status and outputs
  output logic [5:0] stage_pickup_eff,
  output logic [5:0] stage_trip_eff,
  output logic breaker_fail_armed,
  output logic breaker_fail,
  output logic [3:0] relay_out,
  output logic supervision_relay
);
  // elaboration checks on parameters
  generate
    if (PHASE_W < 8 || PHASE_W > 24) begin : g_bad_phase_w
      $error("pbf_core: PHASE_W out of range");
    end
    if (TICK_CYC < 1) begin : g_bad_tick
      $error("pbf_core: TICK_CYC must be at least one");
    end
  endgenerate

  // configuration registers
  logic [6:0] function_blocked_q, function_blocked_d;
  pbf_style_e style_q, style_d;
  logic [11:0] cbf_time_q, cbf_time_d;
  logic [15:0] bt_time_q, bt_time_d;
  pbf_assign_s assign_q, assign_d;

  function automatic logic [11:0] clamp_cbf(input logic [11:0] v);
    if (v < 12'(PBF_CBF_MIN_MS)) return 12'(PBF_CBF_MIN_MS);
    if (v > 12'(PBF_CBF_MAX_MS)) return 12'(PBF_CBF_MAX_MS);
    return v;
  endfunction

  function automatic pbf_style_e legal_style(input pbf_style_e s, input pbf_style_e old);
    if (s == PBF_STYLE_PICKUP || s == PBF_STYLE_TRIP) return s;
    return old;
  endfunction

  // config written from either source, panel wins when both write
  always_comb begin
    function_blocked_d = function_blocked_q;
    style_d = style_q;
    cbf_time_d = cbf_time_q;
    bt_time_d = bt_time_q;
    assign_d = assign_q;
    // RULE16 two sources
    if (serial_cfg_we) begin
      // RULE12 flags and style
      function_blocked_d = serial_function_blocked;
      style_d = legal_style(serial_style, style_q);
      // RULE3 clamp range
      cbf_time_d = clamp_cbf(serial_breaker_fail_time);
      bt_time_d = serial_block_trip_time;
    end
    if (panel_cfg_we) begin
      function_blocked_d = panel_function_blocked;
      style_d = legal_style(panel_style, style_q);
      cbf_time_d = clamp_cbf(panel_breaker_fail_time);
      bt_time_d = panel_block_trip_time;
    end
    // RULE15 assignable relays
    if (serial_assign_we) assign_d = serial_assign;
    if (panel_assign_we) assign_d = panel_assign;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // RULE13 default blocking
      function_blocked_q <= PBF_BLOCK_RST;
      style_q <= PBF_STYLE_PICKUP;
      cbf_time_q <= PBF_CBF_RST_MS;
      bt_time_q <= PBF_BT_RST_MS;
      assign_q <= PBF_ASSIGN_RST;
    end else begin
      function_blocked_q <= function_blocked_d;
      style_q <= style_d;
      cbf_time_q <= cbf_time_d;
      bt_time_q <= bt_time_d;
      assign_q <= assign_d;
    end
  end

  // block/trip timer
  logic bt_run;
  logic bt_expired;
  // RULE10 timer start
  assign bt_run = blocking_input_terminals && (style_q == PBF_STYLE_TRIP);

  // RULE18 tick timer
  pbf_timer #(
    .TICK_CYC(TICK_CYC),
    .W(16)
  ) u_bt_timer (
    .clk(clk),
    .rst(rst),
    .run(bt_run),
    .limit_ms(bt_time_q),
    .expired(bt_expired)
  );

  // stage gating
  logic [5:0] blk_stage;
  logic [5:0] pickup_d, trip_d;
  always_comb begin
    // RULE6 selective block
    blk_stage = blocking_input_terminals ? function_blocked_q[5:0] : 6'h00;
    pickup_d = stage.pickup;
    trip_d = stage.pickup & stage.delay_done;
    if (style_q == PBF_STYLE_PICKUP) begin
      // RULE7 no pickup
      pickup_d = stage.pickup & ~blk_stage;
      trip_d = pickup_d & stage.delay_done;
    end else if (bt_expired) begin
      // RULE9 RULE11 release after timeout
      trip_d = stage.pickup & stage.delay_done;
    end else begin
      // RULE8 hold trip
      trip_d = stage.pickup & stage.delay_done & ~blk_stage;
    end
  end

  // breaker failure supervision
  typedef enum logic [2:0] {
    PBF_CBF_IDLE = 3'b001,
    PBF_CBF_ARMED = 3'b010,
    PBF_CBF_FAIL = 3'b100
  } pbf_cbf_e;

  pbf_cbf_e cbf_q, cbf_d;
  logic [5:0] trip_q;
  logic new_trip;
  logic any_high;
  logic cbf_run;
  logic cbf_expired;
  logic cbf_blocked;
  logic [2:0] ph_high;

  // RULE2 one percent test
  function automatic logic at_or_above(input logic [PHASE_W-1:0] ph, input logic [PHASE_W-1:0] nom);
    logic [31:0] scaled;
    scaled = 32'(ph) * 32'(100 / PBF_THRESH_PCT);
    return scaled >= 32'(nom);
  endfunction

  // RULE2 per phase test
  genvar gp;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_phase
      assign ph_high[gp] = at_or_above(phase_current[gp], nominal_current);
    end
  endgenerate

  assign any_high = |ph_high;
  assign new_trip = |(trip_d & ~trip_q);
  assign cbf_blocked = blocking_input_terminals && function_blocked_q[PBF_F_CBFP];
  assign cbf_run = (cbf_q == PBF_CBF_ARMED) && !new_trip;

  always_comb begin
    cbf_d = cbf_q;
    unique case (cbf_q)
      PBF_CBF_IDLE: begin
        // RULE1 arm on trip
        if (new_trip) cbf_d = PBF_CBF_ARMED;
      end
      PBF_CBF_ARMED: begin
        // RULE5 disarm
        if (!any_high) cbf_d = PBF_CBF_IDLE;
        // RULE4 failure
        else if (cbf_expired && !cbf_blocked) cbf_d = PBF_CBF_FAIL;
      end
      PBF_CBF_FAIL: begin
        if (!any_high) cbf_d = PBF_CBF_IDLE;
      end
      default: cbf_d = PBF_CBF_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cbf_q <= PBF_CBF_IDLE;
      trip_q <= '0;
    end else begin
      cbf_q <= cbf_d;
      trip_q <= trip_d;
    end
  end

  // RULE18 restart on new trip
  pbf_timer #(
    .TICK_CYC(TICK_CYC),
    .W(12)
  ) u_cbf_timer (
    .clk(clk),
    .rst(rst),
    .run(cbf_run),
    .limit_ms(cbf_time_q),
    .expired(cbf_expired)
  );

  // relay drive
  logic [6:0] alarm_src, trip_src;
  logic [3:0] relay_d;
  logic fail_d;
  assign fail_d = (cbf_d == PBF_CBF_FAIL);
  assign alarm_src = {1'b0, pickup_d};
  assign trip_src = {fail_d, trip_d};

  always_comb begin
    relay_d = '0;
    // RULE17 alarm on pickup, trip on delay
    for (int r = 0; r < 4; r++) begin
      relay_d[r] = |(assign_q.alarm[r] & alarm_src) | |(assign_q.trip[r] & trip_src);
    end
  end

  logic sup_q, sup_d;
  logic [5:0] pick_q, tripo_q;
  logic armed_q, armed_d, fail_q;
  logic [3:0] relay_q;

  // output register next values
  always_comb begin
    // health passes to relay five
    sup_d = supervision_ok;
    armed_d = (cbf_d == PBF_CBF_ARMED);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // RULE15 relays off at reset
      relay_q <= '0;
      sup_q <= 1'b0;
      pick_q <= '0;
      tripo_q <= '0;
      armed_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      relay_q <= relay_d;
      // RULE14 supervision relay follows supervision_ok
      sup_q <= sup_d;
      pick_q <= pickup_d;
      tripo_q <= trip_d;
      armed_q <= armed_d;
      fail_q <= fail_d;
    end
  end

  assign relay_out = relay_q;
  assign supervision_relay = sup_q;
  assign stage_pickup_eff = pick_q;
  assign stage_trip_eff = tripo_q;
  assign breaker_fail_armed = armed_q;
  assign breaker_fail = fail_q;
endmodule
`default_nettype wire

// ---- bench/pbf_core_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module pbf_core_properties
  import pbf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched inputs
  input wire logic [2:0][15:0] phase_current,
  input wire logic [15:0] nominal_current,
  input wire pbf_pkg::pbf_stage_s stage,
  input wire logic blocking_input_terminals,
  input wire logic supervision_ok,
  // watched outputs
  input wire logic [5:0] stage_pickup_eff,
  input wire logic [5:0] stage_trip_eff,
  input wire logic breaker_fail_armed,
  input wire logic breaker_fail,
  input wire logic supervision_relay
);
  logic hi;
  always_comb begin
    hi = 1'b0;
    for (int i = 0; i < 3; i++) begin
      hi = hi | ((phase_current[i] * 100) >= nominal_current);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_relay_five: assert property (!$past(rst) && !$past(rst, 2) |-> supervision_relay == $past(supervision_ok))
    else $error("relay five wrong");
  a_pickup_cause: assert property (!$past(rst) |-> (stage_pickup_eff & ~$past(stage.pickup)) == 6'h00)
    else $error("pickup without cause");
  a_trip_cause: assert property (!$past(rst) |-> (stage_trip_eff & ~($past(stage.pickup) & $past(stage.delay_done))) == 6'h00)
    else $error("trip without delay");
  a_free_pickup: assert property (!$past(rst) && !$past(blocking_input_terminals) |-> stage_pickup_eff == $past(stage.pickup))
    else $error("pickup held back");
  a_free_trip: assert property (!$past(rst) && !$past(blocking_input_terminals)
    |-> stage_trip_eff == ($past(stage.pickup) & $past(stage.delay_done)))
    else $error("trip held back");
  a_fail_armed: assert property ($rose(breaker_fail) |-> $past(breaker_fail_armed))
    else $error("fail while idle");
  a_fail_current: assert property (!hi [*3] |=> !breaker_fail)
    else $error("fail with low currents");
  a_fail_early: assert property ($rose(breaker_fail_armed) |=> !breaker_fail [*8])
    else $error("fail too early");
endmodule
bind pbf_core pbf_core_properties chk_u (.clk(clk), .rst(rst), .phase_current(phase_current),
  .nominal_current(nominal_current), .stage(stage), .blocking_input_terminals(blocking_input_terminals),
  .supervision_ok(supervision_ok), .stage_pickup_eff(stage_pickup_eff), .stage_trip_eff(stage_trip_eff),
  .breaker_fail_armed(breaker_fail_armed), .breaker_fail(breaker_fail), .supervision_relay(supervision_relay));
`default_nettype wire

// ---- bench/pbf_stage_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pbf_stage_model
  import pbf_pkg::*;
#(
  parameter int unsigned DELAY = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fault seen by each stage
  input wire logic [5:0] fault,
  // stage levels
  output pbf_pkg::pbf_stage_s stage
);
  logic [5:0] last_q;
  logic [7:0] cnt_q;
  // trip delay restarts on any change of fault
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q <= 6'h00;
      cnt_q <= 8'h00;
    end else begin
      last_q <= fault;
      cnt_q <= (fault != last_q) ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hff};
    end
  end
  // pickup follows the fault, delay flags once the count is reached
  assign stage = {fault, ((cnt_q >= 8'(DELAY)) ? last_q : 6'h00)};
endmodule
`default_nettype wire

// ---- bench/pbf_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module pbf_core_tb;
  import pbf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0][15:0] ph = '0;
  logic [5:0] fault = 6'h00;
  logic blk = 1'b0;
  logic sup_ok = 1'b1;
  logic pwe = 1'b0;
  logic swe = 1'b0;
  logic awe = 1'b0;
  logic pawe = 1'b0;
  logic [6:0] fb = 7'h08;
  pbf_style_e sty = PBF_STYLE_PICKUP;
  logic [11:0] cbf = 12'h0064;
  logic [15:0] bt = 16'h0064;
  pbf_assign_s asg = '0;
  pbf_stage_s stage;
  logic [5:0] pe;
  logic [5:0] te;
  logic armed;
  logic fail;
  logic sup_rel;
  logic [3:0] rel;
  logic [16:0] exp_q[$];
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int k;
  logic [31:0] seed = 32'h5605_827f;
  logic [5:0] m;
  always #2 clk = ~clk;
  pbf_stage_model st_u (.clk(clk), .rst(rst), .fault(fault), .stage(stage));
  pbf_core #(.TICK_CYC(4)) dut_u (.clk(clk), .rst(rst), .phase_current(ph), .nominal_current(16'h03e8),
    .stage(stage), .blocking_input_terminals(blk), .supervision_ok(sup_ok), .panel_cfg_we(pwe),
    .panel_function_blocked(fb), .panel_style(sty), .panel_breaker_fail_time(cbf), .panel_block_trip_time(bt),
    .panel_assign_we(pawe), .panel_assign(asg), .serial_cfg_we(swe), .serial_function_blocked(fb),
    .serial_style(sty), .serial_breaker_fail_time(cbf), .serial_block_trip_time(bt), .serial_assign_we(awe),
    .serial_assign(asg), .stage_pickup_eff(pe), .stage_trip_eff(te), .breaker_fail_armed(armed),
    .breaker_fail(fail), .relay_out(rel), .supervision_relay(sup_rel));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(string what, logic [16:0] seen, logic [16:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask
  // relays from alarm and trip masks
  task automatic note(logic [5:0] p, logic [5:0] t, logic f);
    logic [3:0] r;
    for (int i = 0; i < 4; i++) begin
      r[i] = |(asg.alarm[i][5:0] & p) | |(asg.trip[i][5:0] & t) | (asg.trip[i][6] & f);
    end
    exp_q.push_back({p, t, f, r});
  endtask
  task automatic cfg(logic [6:0] b, pbf_style_e s, logic [11:0] c, logic [15:0] t, logic ser);
    @(posedge clk);
    fb <= b;
    sty <= s;
    cbf <= c;
    bt <= t;
    blk <= 1'b0;
    fault <= 6'h00;
    pwe <= !ser;
    swe <= ser;
    @(posedge clk);
    pwe <= 1'b0;
    swe <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(negedge clk) begin
    if (exp_q.size() > 0) begin
      check("outputs", {pe, te, fail, rel}, exp_q.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    asg.alarm[0] = 7'h3f;
    asg.trip[1] = 7'h3f;
    asg.alarm[2] = 7'h05;
    asg.trip[2] = 7'h22;
    asg.trip[3] = 7'h40;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    blk <= 1'b1;
    fault <= 6'h3f;
    repeat (12) @(posedge clk);
    exp_q.push_back({6'h37, 6'h37, 1'b0, 4'h0});
    @(negedge clk);
    check("relay five", {16'h0000, sup_rel}, 17'h00001);
    @(posedge clk);
    sup_ok <= 1'b0;
    awe <= 1'b1;
    @(posedge clk);
    awe <= 1'b0;
    pawe <= 1'b1;
    @(posedge clk);
    pawe <= 1'b0;
    @(negedge clk);
    check("relay five", {16'h0000, sup_rel}, 17'h00000);
    $display("test defaults done");
    for (int n = 0; n < 24; n++) begin
      seed = lfsr(seed);
      cfg(seed[6:0], seed[7] ? PBF_STYLE_TRIP : PBF_STYLE_PICKUP, 12'h0064, 16'h0064, seed[8]);
      m = seed[5:0] & {6{seed[9]}};
      blk <= seed[9];
      fault <= seed[15:10];
      repeat (3) @(posedge clk);
      note(seed[15:10] & ~(seed[7] ? 6'h00 : m), 6'h00, 1'b0);
      repeat (10) @(posedge clk);
      note(seed[15:10] & ~(seed[7] ? 6'h00 : m), seed[15:10] & ~m, 1'b0);
    end
    $display("test blocking done");
    cfg(7'h3f, PBF_STYLE_TRIP, 12'h0064, 16'h0004, 1'b0);
    blk <= 1'b1;
    fault <= 6'h3f;
    repeat (13) @(posedge clk);
    note(6'h3f, 6'h00, 1'b0);
    repeat (12) @(posedge clk);
    note(6'h3f, 6'h3f, 1'b0);
    $display("test block trip done");
    cfg(7'h00, PBF_STYLE_PICKUP, 12'h0032, 16'h0064, 1'b1);
    ph <= {16'h000a, 16'h0000, 16'h0000};
    fault <= 6'h01;
    k = 0;
    while (fail !== 1'b1 && k < 600) begin
      @(negedge clk);
      k++;
      if (k == 200) check("armed", {16'h0000, armed}, 17'h00001);
    end
    check("fail time", {16'h0000, k >= 400 && k <= 440}, 17'h00001);
    @(posedge clk);
    note(6'h01, 6'h01, 1'b1);
    ph <= {16'h0000, 16'h0000, 16'h0009};
    repeat (4) @(posedge clk);
    note(6'h01, 6'h01, 1'b0);
    fault <= 6'h00;
    repeat (10) @(posedge clk);
    fault <= 6'h02;
    repeat (450) @(posedge clk);
    note(6'h02, 6'h02, 1'b0);
    @(negedge clk);
    check("armed", {16'h0000, armed}, 17'h00000);
    $display("test breaker done");
    repeat (3) @(negedge clk);
    print_verdict();
  end
endmodule
`default_nettype wire
